// ---- rtl/ued_pkg.sv ----
// Purpose: shared constants and types of the endpoint control block
// Assumes: one endpoint per device instance, byte-wide FIFO data
// Notes: a two-bit select stands in for addresses
// Functional notes
// R1: tx ready set by firmware, cleared by device
// R2: device runs IN, then flags tx complete
// R3: firmware loads only while tx ready reads 0
// R4: force halt is write-one, answers STALL
// R5: acknowledged STALL sets halt acknowledged flag
// R6: bank 1 flag set when bank 1 holds packet
// R7: interrupt held while bank 1 flag set
// R8: firmware writes 0 to release bank 1
// R9: direction bit picks control data stage direction
// R10: firmware sets direction before clearing setup flag
// R11: three-bit endpoint kind encoding
// R12: toggle bit reads DATA0 as 0, DATA1 as 1
// R13: enable bit reads back and sets endpoint state
// R14: eleven-bit received byte count, read-only
// R15: firmware reads exactly the received byte count
// R16: FIFO data register pushes and pops bytes
// R17: firmware never exceeds max packet or FIFO
// R18: bit 8 powers down the transceiver
// R19: OUT data refused while setup flag set
// R20: write 0 clears tx complete, 1 ignored
// R21: write 0 clears halt acknowledged
// R22: unused data and transceiver bits read zero
package ued_pkg;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 11;
   localparam int REG_W = 32;
   localparam int MAX_PKT = 16;
   // Status and control bit positions
   localparam int B_TX_COMPLETE = 0;
   localparam int B_BK0 = 1;
   localparam int B_SETUP = 2;
   localparam int B_STALL = 3;
   localparam int B_TXRDY = 4;
   localparam int B_FORCE = 5;
   localparam int B_BK1 = 6;
   localparam int B_DIR = 7;
   localparam int B_KIND = 8;
   localparam int B_TOG = 11;
   localparam int B_ON = 15;
   localparam int B_CNT = 16;
   localparam int B_XOFF = 8;
   localparam logic [2:0] KIND_CTRL = 3'h0;
   localparam logic [REG_W-1:0] REG_ZERO = 32'h0000_0000;
   localparam logic [REG_W-1:0] REG_ONE = 32'h0000_0001;
   typedef enum logic [1:0] {SEL_CSR = 2'h0, SEL_FDR = 2'h1, SEL_XCVR = 2'h2} ued_sel_t;
   typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_STALL = 2'h2} ued_hs_t;
endpackage

// ---- rtl/ued_reg_if.sv ----
// Purpose: register port between endpoint logic and its firmware agent
// Assumes: both ends on clk_sys; reads answer one cycle later
// Notes: irq is a level, high while any event flag is set
interface ued_reg_if;
   ued_pkg::ued_sel_t regSel;
   logic regWr;
   logic regRd;
   logic [ued_pkg::REG_W-1:0] regWdata;
   logic [ued_pkg::REG_W-1:0] regRdata;
   logic regRdValid;
   logic irq;
   modport dev (input regSel, regWr, regRd, regWdata, output regRdata, regRdValid, irq);
   modport fw (output regSel, regWr, regRd, regWdata, input regRdata, regRdValid, irq);
endinterface

// ---- rtl/ued_fifo.sv ----
// Purpose: flop-based FIFO with valid/ready on both sides
// Assumes: push and pop may happen in the same cycle
// Notes: inReady drops when full, so the writer stalls
module ued_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [W-1:0] outData,
   input wire logic outReady
);
   import ued_pkg::*;
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ued_fifo_st_t;
   ued_fifo_st_t s, next_s;
   logic push, pop;

   // Explicit wrap lets depth be any value
   function automatic logic [AW-1:0] nextPtr(logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   // Full and empty from the fill count
   assign inReady = s.cnt != (AW + 1)'(DEPTH);
   assign outValid = s.cnt != '0;
   assign outData = s.mem[s.rp];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Pointer and count update
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = inData;
         next_s.wp = nextPtr(s.wp);
      end
      if (pop) begin
         next_s.rp = nextPtr(s.rp);
      end
      if (push && !pop) begin
         next_s.cnt = (AW + 1)'(s.cnt + 1'b1);
      end else if (pop && !push) begin
         next_s.cnt = (AW + 1)'(s.cnt - 1'b1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- rtl/ued_device_end.sv ----
// Purpose: endpoint control and status logic, register side and bus side
// Assumes: a serial engine on clk_sys gives tokens and bytes
// Notes: banks share one receive FIFO and drain in fill order
module ued_device_end #(
   parameter bit PING_PONG = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   ued_reg_if.dev regs,
   input wire logic busTokIn,
   input wire logic busOutValid,
   input wire logic [ued_pkg::DATA_W-1:0] busOutData,
   input wire logic busOutLast,
   input wire logic busOutSetup,
   input wire logic busOutToggle,
   output logic busOutReady,
   output logic busTxValid,
   output logic [ued_pkg::DATA_W-1:0] busTxData,
   output logic busTxLast,
   input wire logic busTxReady,
   input wire logic busInAck,
   output logic busHsValid,
   output ued_pkg::ued_hs_t busHsCode,
   output logic xcvrOff
);
   import ued_pkg::*;
   typedef enum logic [4:0] {
      D_IDLE = 5'h01,
      D_RECV = 5'h02,
      D_DROP = 5'h04,
      D_SEND = 5'h08,
      D_WAIT = 5'h10
   } ued_dstate_t;
   typedef struct packed {
      ued_dstate_t st;
      logic tx_complete, bk0, bk1, setupRx, haltAck, txRdy, forceHalt, dir, tog, epOn, xOff;
      logic [2:0] kind;
      logic fillBk, drainBk, curBk, isSetup;
      logic [CNT_W-1:0] cnt0, cnt1, rcv, txLen, txLeft;
      ued_hs_t pend;
      logic hsValid;
      ued_hs_t hsCode;
      logic rdValid;
      logic [REG_W-1:0] rdata;
   } ued_dev_st_t;
   ued_dev_st_t s, next_s;

   logic txPush, txInReady, txOutValid, txPop;
   logic rxPush, rxInReady, rxOutValid, rxPop;
   logic [DATA_W-1:0] txOutData, rxOutData;
   logic live, ctrl, ppOn;
   logic [REG_W-1:0] w;

   // Status word; count of the bank draining next
   function automatic logic [REG_W-1:0] csrView(ued_dev_st_t v);
      logic [REG_W-1:0] r;
      r = REG_ZERO;
      r[B_TX_COMPLETE] = v.tx_complete;
      r[B_BK0] = v.bk0;
      r[B_SETUP] = v.setupRx;
      r[B_STALL] = v.haltAck;
      r[B_TXRDY] = v.txRdy;
      r[B_BK1] = v.bk1; // R6
      r[B_DIR] = v.dir;
      r[B_KIND +: 3] = v.kind; // R11
      r[B_TOG] = v.tog; // R12
      r[B_ON] = v.epOn; // R13
      r[B_CNT +: CNT_W] = (v.setupRx || !v.drainBk) ? v.cnt0 : v.cnt1; // R14
      return r;
   endfunction

   ued_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) txFifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(txPush),
      .inData(regs.regWdata[DATA_W-1:0]),
      .inReady(txInReady),
      .outValid(txOutValid),
      .outData(txOutData),
      .outReady(txPop)
   );

   ued_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) rxFifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .inValid(rxPush),
      .inData(busOutData),
      .inReady(rxInReady),
      .outValid(rxOutValid),
      .outData(rxOutData),
      .outReady(rxPop)
   );

   // Strobes; pushes blocked while a packet waits
   assign w = regs.regWdata;
   assign live = s.epOn && !s.xOff;
   assign ctrl = s.kind == KIND_CTRL;
   assign ppOn = PING_PONG && !ctrl;
   assign txPush = regs.regWr && regs.regSel == SEL_FDR && !s.txRdy; // R1 R16
   assign rxPop = regs.regRd && regs.regSel == SEL_FDR && rxOutValid; // R16
   assign busOutReady = (s.st == D_RECV) ? rxInReady : (s.st == D_DROP);
   assign rxPush = s.st == D_RECV && busOutValid && rxInReady;
   assign busTxValid = s.st == D_SEND && txOutValid;
   assign busTxData = txOutData;
   assign busTxLast = s.txLeft == CNT_W'(1);
   assign txPop = busTxValid && busTxReady;

   // Outputs from state flops
   assign busHsValid = s.hsValid;
   assign busHsCode = s.hsCode;
   assign xcvrOff = s.xOff; // R18
   assign regs.regRdata = s.rdata;
   assign regs.regRdValid = s.rdValid;
   assign regs.irq = s.tx_complete | s.bk0 | s.bk1 | s.setupRx | s.haltAck; // R7

   // Register side first so a hardware set wins a clear
   always_comb begin
      logic tgt;
      tgt = 1'b0;
      next_s = s;
      next_s.hsValid = 1'b0;
      next_s.rdValid = 1'b0;
      if (regs.regWr) begin
         unique case (regs.regSel)
            SEL_CSR: begin
               if (!w[B_TX_COMPLETE]) next_s.tx_complete = 1'b0; // R20
               if (!w[B_BK0] && s.bk0) begin
                  next_s.bk0 = 1'b0;
                  next_s.drainBk = ppOn;
               end
               if (!w[B_BK1] && s.bk1) begin
                  next_s.bk1 = 1'b0; // R8
                  next_s.drainBk = 1'b0;
               end
               if (!w[B_SETUP]) next_s.setupRx = 1'b0;
               if (!w[B_STALL]) next_s.haltAck = 1'b0; // R21
               if (w[B_TXRDY]) next_s.txRdy = 1'b1; // R1
               if (w[B_FORCE]) next_s.forceHalt = 1'b1; // R4
               next_s.dir = w[B_DIR]; // R9
               next_s.kind = w[B_KIND +: 3]; // R11
               next_s.epOn = w[B_ON]; // R13
            end
            SEL_FDR: begin
               if (txPush && txInReady) next_s.txLen = CNT_W'(s.txLen + 1'b1);
            end
            SEL_XCVR: next_s.xOff = w[B_XOFF]; // R18 R22
            default: ;
         endcase
      end
      // Reads answer next cycle; unused bits stay zero
      if (regs.regRd) begin
         next_s.rdValid = 1'b1;
         unique case (regs.regSel)
            SEL_CSR: next_s.rdata = csrView(s);
            SEL_FDR: next_s.rdata = {{(REG_W - DATA_W){1'b0}}, rxOutData}; // R16 R22
            SEL_XCVR: next_s.rdata = REG_ONE << B_XOFF & {REG_W{s.xOff}}; // R22
            default: next_s.rdata = REG_ZERO;
         endcase
      end
      unique case (s.st)
         D_IDLE: begin
            if (busTokIn) begin
               next_s.hsValid = 1'b1;
               next_s.hsCode = HS_NAK;
               if (live && s.forceHalt) begin
                  next_s.hsCode = HS_STALL; // R4
                  next_s.haltAck = 1'b1; // R5
               end else if (live && s.txRdy) begin
                  next_s.hsValid = 1'b0; // R2
                  next_s.txLeft = s.txLen;
                  next_s.st = (s.txLen == '0) ? D_WAIT : D_SEND;
               end
            end else if (busOutValid) begin
               // Fate decided before the first byte is taken
               next_s.rcv = '0;
               next_s.isSetup = busOutSetup && ctrl;
               next_s.st = D_DROP;
               next_s.pend = HS_NAK;
               tgt = ppOn ? s.fillBk : 1'b0;
               if (!live) begin
                  next_s.pend = HS_NAK;
               end else if (busOutSetup && ctrl) begin
                  if (!s.bk0 && !s.setupRx) begin
                     next_s.st = D_RECV;
                     next_s.curBk = 1'b0;
                  end
               end else if (s.forceHalt) begin
                  next_s.pend = HS_STALL; // R4
               end else if (ctrl && s.setupRx) begin
                  next_s.pend = HS_NAK; // R19
               end else if (ctrl && s.dir) begin
                  next_s.pend = HS_ACK; // R9
               end else if (!(tgt ? s.bk1 : s.bk0)) begin
                  next_s.st = D_RECV;
                  next_s.curBk = tgt;
               end
            end
         end
         D_RECV: begin
            if (rxPush) begin
               next_s.rcv = CNT_W'(s.rcv + 1'b1);
               if (busOutLast) begin
                  next_s.st = D_IDLE;
                  next_s.hsValid = 1'b1;
                  next_s.hsCode = HS_ACK;
                  next_s.tog = busOutToggle; // R12
                  if (s.curBk) begin
                     next_s.bk1 = 1'b1; // R6
                     next_s.cnt1 = CNT_W'(s.rcv + 1'b1); // R14
                  end else begin
                     next_s.cnt0 = CNT_W'(s.rcv + 1'b1); // R14
                     // Set on top of this cycle's writes, so a clear never erases it
                     if (s.isSetup) next_s.setupRx = 1'b1;
                     else next_s.bk0 = 1'b1;
                  end
                  if (s.isSetup) next_s.forceHalt = 1'b0;
                  if (ppOn && !s.isSetup) next_s.fillBk = !s.curBk;
               end
            end
         end
         D_DROP: begin
            if (busOutValid && busOutLast) begin
               next_s.st = D_IDLE;
               next_s.hsValid = live;
               next_s.hsCode = s.pend;
               if (s.pend == HS_STALL) next_s.haltAck = 1'b1; // R5
            end
         end
         D_SEND: begin
            if (txPop) begin
               next_s.txLeft = CNT_W'(s.txLeft - 1'b1);
               if (busTxLast) next_s.st = D_WAIT;
            end
         end
         D_WAIT: begin
            if (busInAck) begin
               next_s.st = D_IDLE;
               next_s.tx_complete = 1'b1; // R2
               next_s.txRdy = 1'b0; // R1
               next_s.txLen = '0;
               next_s.tog = !s.tog;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.st <= D_IDLE;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- rtl/ued_firmware_end.sv ----
// Purpose: firmware agent that drives the endpoint registers
// Assumes: one endpoint, polled; user streams are on clk_sys
// Notes: every status write carries 1 in each event bit it keeps
module ued_firmware_end #(
   parameter bit PING_PONG = 1'b1,
   parameter int MAX_BYTES = ued_pkg::MAX_PKT
) (
   input wire logic clk_sys,
   input wire logic rst,
   ued_reg_if.fw regs,
   input wire logic [2:0] cfgKind,
   input wire logic cfgDir,
   input wire logic cfgOn,
   input wire logic haltReq,
   input wire logic sendValid,
   input wire logic [ued_pkg::DATA_W-1:0] sendData,
   input wire logic sendLast,
   output logic sendReady,
   output logic recvValid,
   output logic [ued_pkg::DATA_W-1:0] recvData,
   output logic recvLast,
   output logic recvSetup
);
   import ued_pkg::*;
   typedef enum logic [5:0] {
      F_POLL = 6'h01,
      F_WAIT = 6'h02,
      F_READ = 6'h04,
      F_RWAIT = 6'h08,
      F_LOAD = 6'h10,
      F_ARM = 6'h20
   } ued_fstate_t;
   typedef struct packed {
      ued_fstate_t st;
      logic wr, rd;
      ued_sel_t sel;
      logic [REG_W-1:0] wdata, clr;
      logic [CNT_W-1:0] left, cnt;
      logic readBk, haltPend, isSetup;
      logic recvValid, recvLast, recvSetup;
      logic [DATA_W-1:0] recvData;
   } ued_fw_st_t;
   ued_fw_st_t s, next_s;
   logic [REG_W-1:0] c;
   logic bk, ppOn;

   // Config, event bits at 1, less clr, plus setm
   function automatic logic [REG_W-1:0] csrWord(logic [REG_W-1:0] clr, logic [REG_W-1:0] setm);
      logic [REG_W-1:0] r;
      r = REG_ZERO;
      r[B_TX_COMPLETE] = 1'b1;
      r[B_BK0] = 1'b1;
      r[B_SETUP] = 1'b1;
      r[B_STALL] = 1'b1;
      r[B_BK1] = 1'b1;
      r[B_DIR] = cfgDir; // R10
      r[B_KIND +: 3] = cfgKind;
      r[B_ON] = cfgOn;
      return (r & ~clr) | setm;
   endfunction

   assign c = regs.regRdata;
   assign ppOn = PING_PONG && cfgKind != KIND_CTRL;
   assign bk = ppOn && s.readBk;
   assign sendReady = s.st == F_LOAD;
   assign regs.regWr = s.wr;
   assign regs.regRd = s.rd;
   assign regs.regSel = s.sel;
   assign regs.regWdata = s.wdata;
   assign recvValid = s.recvValid;
   assign recvData = s.recvData;
   assign recvLast = s.recvLast;
   assign recvSetup = s.recvSetup;

   // Poll, then serve one event per pass; tx complete and halt acknowledged clear in one write
   always_comb begin
      next_s = s;
      next_s.wr = 1'b0;
      next_s.rd = 1'b0;
      next_s.recvValid = 1'b0;
      next_s.recvLast = 1'b0;
      if (haltReq) next_s.haltPend = 1'b1;
      unique case (s.st)
         F_POLL: begin
            next_s.rd = 1'b1;
            next_s.sel = SEL_CSR;
            next_s.st = F_WAIT;
         end
         F_WAIT: begin
            if (regs.regRdValid) begin
               next_s.st = F_POLL;
               next_s.wr = 1'b1;
               next_s.sel = SEL_CSR;
               next_s.wdata = csrWord(REG_ZERO, REG_ZERO);
               if (s.haltPend) begin
                  next_s.haltPend = 1'b0;
                  next_s.wdata = csrWord(REG_ZERO, REG_ONE << B_FORCE);
               end else if (c[B_SETUP] || (bk ? c[B_BK1] : c[B_BK0])) begin
                  next_s.isSetup = c[B_SETUP];
                  next_s.clr = REG_ONE << (c[B_SETUP] ? B_SETUP : bk ? B_BK1 : B_BK0);
                  next_s.left = c[B_CNT +: CNT_W];
                  if (c[B_CNT +: CNT_W] == '0) begin
                     next_s.wdata = csrWord(next_s.clr, REG_ZERO); // R8
                     if (!c[B_SETUP]) next_s.readBk = ppOn && !s.readBk;
                  end else begin
                     next_s.wr = 1'b0;
                     next_s.st = F_READ;
                  end
               end else if (c[B_TX_COMPLETE] || c[B_STALL]) begin
                  next_s.wdata = csrWord(c & (REG_ONE << B_TX_COMPLETE | REG_ONE << B_STALL), REG_ZERO);
               end else if (!c[B_TXRDY] && sendValid) begin
                  next_s.wr = 1'b0; // R3
                  next_s.cnt = '0;
                  next_s.st = F_LOAD;
               end
            end
         end
         F_READ: begin
            next_s.rd = 1'b1;
            next_s.sel = SEL_FDR;
            next_s.st = F_RWAIT;
         end
         F_RWAIT: begin
            if (regs.regRdValid) begin
               // Exactly the reported count is popped
               next_s.recvValid = 1'b1; // R15
               next_s.recvData = c[DATA_W-1:0];
               next_s.recvSetup = s.isSetup;
               next_s.recvLast = s.left == CNT_W'(1);
               next_s.left = CNT_W'(s.left - 1'b1);
               next_s.st = F_READ;
               if (s.left == CNT_W'(1)) begin
                  next_s.st = F_POLL;
                  next_s.wr = 1'b1;
                  next_s.sel = SEL_CSR;
                  next_s.wdata = csrWord(s.clr, REG_ZERO); // R8 R10
                  if (!s.isSetup) next_s.readBk = ppOn && !s.readBk;
               end
            end
         end
         F_LOAD: begin
            if (sendValid) begin
               next_s.wr = 1'b1;
               next_s.sel = SEL_FDR;
               next_s.wdata = {{(REG_W - DATA_W){1'b0}}, sendData};
               next_s.cnt = CNT_W'(s.cnt + 1'b1);
               // Cap keeps a packet in the FIFO
               if (sendLast || s.cnt == CNT_W'(MAX_BYTES - 1)) next_s.st = F_ARM; // R17
            end
         end
         F_ARM: begin
            next_s.wr = 1'b1; // R3
            next_s.sel = SEL_CSR;
            next_s.wdata = csrWord(REG_ZERO, REG_ONE << B_TXRDY);
            next_s.st = F_POLL;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.st <= F_POLL;
      end else begin
         s <= next_s;
      end
   end
endmodule

// ---- verification/ued_reg_props.sv ----
// Purpose: checker on the register port between the endpoint ends
// Assumes: one clk_sys domain; reads answer one cycle on
// Notes: copies taken at the strobe edge; a read shows old state
module ued_reg_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire ued_pkg::ued_sel_t regSel,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [ued_pkg::REG_W-1:0] regWdata,
   input wire logic [ued_pkg::REG_W-1:0] regRdata,
   input wire logic regRdValid,
   input wire logic irq
);
   import ued_pkg::*;
   logic [4:0] shadow, cfgAtRd, evt, cfgRd;
   logic csrAns, fdrAns, irqAtRd;
   // Event flags and writable fields of a status answer
   assign evt = {regRdata[B_BK1], regRdata[B_STALL:B_TX_COMPLETE]};
   assign cfgRd = {regRdata[B_ON], regRdata[B_DIR], regRdata[B_KIND+:3]};
   // Shadow of status writes, seen by reads one cycle on
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shadow <= 5'h00;
         cfgAtRd <= 5'h00;
         csrAns <= 1'b0;
         fdrAns <= 1'b0;
         irqAtRd <= 1'b0;
      end else begin
         if (regWr && regSel == SEL_CSR) begin
            shadow <= {regWdata[B_ON], regWdata[B_DIR], regWdata[B_KIND+:3]};
         end
         cfgAtRd <= shadow;
         csrAns <= regRd && regSel == SEL_CSR;
         fdrAns <= regRd && regSel == SEL_FDR;
         irqAtRd <= irq;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_read_answered: assert property (regRd |=> regRdValid)
      else $error("read not answered next cycle");
   a_answer_caused: assert property (regRdValid |-> $past(regRd))
      else $error("answer without a read");
   a_fifo_high_zero: assert property (fdrAns |-> regRdata[31:8] == 24'h0)
      else $error("data register high bits set");
   a_force_reads_zero: assert property (csrAns |-> !regRdata[B_FORCE])
      else $error("force halt bit read back");
   a_count_width: assert property (csrAns |-> regRdata[31:27] == 5'h0)
      else $error("byte count wider than eleven bits");
   a_event_irq_high: assert property (csrAns && evt != 5'h0 |-> irqAtRd)
      else $error("event flag set with irq low");
   a_quiet_irq_low: assert property (csrAns && evt == 5'h0 |-> !irqAtRd)
      else $error("irq high with no event flag");
   a_cfg_readback: assert property (csrAns |-> cfgRd == cfgAtRd)
      else $error("kind, direction or enable lost");
endmodule

// ---- verification/tb_top.sv ----
// Purpose: bench joining device end and firmware end
// Assumes: firmware end polls status, writes config back
// Notes: OUT packets run from a table; IN, halt and disable by hand
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ued_pkg::*;
   typedef struct packed {
      logic [2:0] kind;
      logic setup;
      logic [7:0] len;
      logic [7:0] pre;
      logic [1:0] hs;
   } ued_row_t;
   // Setup, refused OUT, two bulk banks, full-size packet
   ued_row_t rows [5] = '{'{3'h0, 1'b1, 8'h08, 8'h28, 2'h0}, '{3'h0, 1'b0, 8'h02, 8'h00, 2'h1},
      '{3'h2, 1'b0, 8'h03, 8'h50, 2'h0}, '{3'h2, 1'b0, 8'h05, 8'h00, 2'h0},
      '{3'h3, 1'b0, 8'h10, 8'h50, 2'h0}};
   logic clk_sys = 1'b0, rst = 1'b1, cfgDir = 1'b0, cfgOn = 1'b1, haltReq = 1'b0;
   logic sendValid = 1'b0, sendLast = 1'b0, busTokIn = 1'b0, busInAck = 1'b0;
   logic busTxReady = 1'b0, busOutValid = 1'b0, busOutLast = 1'b0;
   logic busOutSetup = 1'b0, busOutToggle = 1'b0;
   logic [2:0] cfgKind = 3'h6;
   logic [7:0] sendData = 8'h00, busOutData = 8'h00, recvData, busTxData;
   logic sendReady, recvValid, recvLast, recvSetup, busOutReady, busTxValid, busTxLast;
   logic busHsValid, xcvrOff;
   ued_hs_t busHsCode;
   logic [1:0] hsCode;
   logic [9:0] recvQ [$], expQ [$];
   logic [31:0] csrVal;
   int errTotal = 0, testsRun = 0, hsCount = 0, cycles = 0;
   always #5 clk_sys = ~clk_sys;
   ued_reg_if i_ued_reg_if ();
   ued_device_end i_ued_device_end (.clk_sys, .rst, .regs(i_ued_reg_if), .busTokIn,
      .busOutValid, .busOutData, .busOutLast, .busOutSetup, .busOutToggle, .busOutReady,
      .busTxValid, .busTxData, .busTxLast, .busTxReady, .busInAck, .busHsValid, .busHsCode,
      .xcvrOff);
   ued_firmware_end i_ued_firmware_end (.clk_sys, .rst, .regs(i_ued_reg_if), .cfgKind, .cfgDir,
      .cfgOn, .haltReq, .sendValid, .sendData, .sendLast, .sendReady, .recvValid, .recvData,
      .recvLast, .recvSetup);
   ued_reg_props i_ued_reg_props (.clk_sys, .rst, .regSel(i_ued_reg_if.regSel),
      .regWr(i_ued_reg_if.regWr), .regRd(i_ued_reg_if.regRd), .regWdata(i_ued_reg_if.regWdata),
      .regRdata(i_ued_reg_if.regRdata), .regRdValid(i_ued_reg_if.regRdValid),
      .irq(i_ued_reg_if.irq));
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         errTotal++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Handshakes and delivered bytes
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (busHsValid === 1'b1) begin
         hsCount <= hsCount + 1;
         hsCode <= busHsCode;
      end
      if (recvValid === 1'b1) recvQ.push_back({recvSetup, recvLast, recvData});
      if (cycles == 20000) begin
         errTotal++;
         tally_and_finish();
      end
   end
   task automatic tok();
      busTokIn = 1'b1;
      step();
      busTokIn = 1'b0;
   endtask
   // Code 3 means no handshake in time
   task automatic waitHs(input logic [1:0] exp);
      int n0;
      n0 = hsCount;
      for (int t = 0; t < 40 && hsCount == n0; t++) step();
      check((hsCount == n0) ? 32'h3 : {30'h0, hsCode}, {30'h0, exp});
   endtask
   // Ready sampled mid-cycle, so the taking edge is known
   task automatic sendOut(input logic setup, input int len, input logic [7:0] base);
      int i;
      logic rdy;
      i = 0;
      busOutSetup = setup;
      busOutData = base;
      busOutLast = (len == 1);
      busOutValid = 1'b1;
      for (int t = 0; t < 200 && i < len; t++) begin
         #1;
         rdy = busOutReady;
         step();
         if (rdy) begin
            i++;
            busOutData = base + 8'(i);
            busOutLast = (i == len - 1);
         end
      end
      busOutValid = 1'b0;
      busOutLast = 1'b0;
   endtask
   // Load via firmware end, serve one IN, host stalls
   task automatic runIn(input int len, input logic [7:0] base);
      int i;
      logic tak;
      i = 0;
      sendValid = 1'b1;
      sendData = base;
      sendLast = (len == 1);
      for (int t = 0; t < 200 && i < len; t++) begin
         #1;
         tak = sendReady;
         step();
         if (tak) begin
            i++;
            sendData = base + 8'(i);
            sendLast = (i == len - 1);
         end
      end
      sendValid = 1'b0;
      sendLast = 1'b0;
      repeat (30) step();
      check({31'h0, sendReady}, 32'h0);
      tok();
      i = 0;
      for (int t = 0; t < 100 && i < len; t++) begin
         busTxReady = t[0];
         #1;
         if (busTxValid === 1'b1 && busTxReady) begin
            check({busTxLast, busTxData}, {i == len - 1, base + 8'(i)});
            i++;
         end
         step();
      end
      check(32'(i), 32'(len));
      busTxReady = 1'b0;
      busInAck = 1'b1;
      step();
      busInAck = 1'b0;
      repeat (3) step();
      for (int t = 0; t < 100; t++) begin
         if (i_ued_reg_if.regRd === 1'b1 && i_ued_reg_if.regSel === SEL_CSR) break;
         step();
      end
      step();
      csrVal = i_ued_reg_if.regRdata;
   endtask
   initial begin
      repeat (5) step();
      rst = 1'b0;
      repeat (40) step();
      // Toggle flips on each acknowledged IN; empty endpoint NAKs
      runIn(4, 8'hA0);
      check({csrVal[B_TOG], csrVal[B_TXRDY]}, 32'h2);
      tok();
      waitHs(HS_NAK);
      runIn(1, 8'h5C);
      check({31'h0, csrVal[B_TOG]}, 32'h0);
      // Forced halt stalls both ways until a setup
      haltReq = 1'b1;
      step();
      haltReq = 1'b0;
      repeat (40) step();
      tok();
      waitHs(HS_STALL);
      sendOut(1'b0, 2, 8'h11);
      waitHs(HS_STALL);
      // Every kind except 4, and both directions, through the readback checker
      for (int k = 0; k < 8; k++) begin
         if (k != 4) begin
            cfgKind = 3'(k);
            cfgDir = k[0];
            repeat (30) step();
         end
      end
      cfgDir = 1'b0;
      foreach (rows[r]) begin
         cfgKind = rows[r].kind;
         repeat (rows[r].pre) step();
         busOutToggle = r[0];
         sendOut(rows[r].setup, int'(rows[r].len), 8'(r << 4));
         waitHs(rows[r].hs);
         for (int i = 0; i < rows[r].len && rows[r].hs == HS_ACK; i++) begin
            expQ.push_back({rows[r].setup, i == rows[r].len - 1, 8'(r << 4) + 8'(i)});
         end
      end
      repeat (100) step();
      check(32'(recvQ.size()), 32'(expQ.size()));
      foreach (expQ[i]) check({22'h0, recvQ[i]}, {22'h0, expQ[i]});
      // Disabled endpoint NAKs IN, drops OUT silently
      cfgOn = 1'b0;
      repeat (40) step();
      tok();
      waitHs(HS_NAK);
      sendOut(1'b0, 1, 8'h77);
      waitHs(2'h3);
      check({31'h0, xcvrOff}, 32'h0);
      tally_and_finish();
   end
endmodule
